// ===== rtl/sowd_pkg.sv
package sowd_pkg;

  localparam int          SOWD_AW              = 3;
  // Register indices on the plain register port
  localparam logic [2:0]  SOWD_ADDR_OPT1       = 3'h0;
  localparam logic [2:0]  SOWD_ADDR_OPT2       = 3'h1;
  localparam logic [2:0]  SOWD_ADDR_IDH        = 3'h2;
  localparam logic [2:0]  SOWD_ADDR_IDL        = 3'h3;
  localparam logic [2:0]  SOWD_ADDR_RST_STATUS = 3'h4;

  // Field positions, first options register
  localparam int          SOWD_OPT1_TMO_HI     = 7;
  localparam int          SOWD_OPT1_TMO_LO     = 6;
  localparam int          SOWD_OPT1_STOP       = 5;
  localparam int          SOWD_OPT1_SER2       = 4;
  localparam int          SOWD_OPT1_TWI        = 3;
  // Field positions, second options register
  localparam int          SOWD_OPT2_CLKSEL     = 7;
  localparam int          SOWD_OPT2_WINDOW     = 6;
  localparam int          SOWD_OPT2_TRIG       = 4;
  localparam int          SOWD_OPT2_DIV_HI     = 2;

  // Reset values: watchdog on, longest 1 kHz timeout, stop allowed
  localparam logic [7:0]  SOWD_OPT1_RESET      = 8'he0;
  localparam logic [7:0]  SOWD_OPT2_RESET      = 8'h00;
  localparam logic [7:0]  SOWD_OPT1_WMASK      = 8'hf8;
  localparam logic [7:0]  SOWD_OPT2_WMASK      = 8'hd7;

  localparam logic [7:0]  SOWD_SERVICE_FIRST   = 8'h55;
  localparam logic [7:0]  SOWD_SERVICE_SECOND  = 8'haa;

  // Overflow exponents and window opening counts
  localparam int          SOWD_LPO_EXP1        = 5;
  localparam int          SOWD_LPO_EXP2        = 8;
  localparam int          SOWD_LPO_EXP3        = 10;
  localparam int          SOWD_BUS_EXP1        = 13;
  localparam int          SOWD_BUS_EXP2        = 16;
  localparam int          SOWD_BUS_EXP3        = 18;
  localparam logic [18:0] SOWD_WIN_OPEN1       = 19'd6144;
  localparam logic [18:0] SOWD_WIN_OPEN2       = 19'd49152;
  localparam logic [18:0] SOWD_WIN_OPEN3       = 19'd196608;

  // 1 kHz low-power clock derived from the 100 MHz bus clock
  localparam int          SOWD_CLK_HZ          = 100000000;
  localparam int          SOWD_LPO_HZ          = 1000;
  localparam int          SOWD_LPO_DIV         = SOWD_CLK_HZ / SOWD_LPO_HZ;

  typedef struct packed {
    logic [1:0] timeout_sel;
    logic       clock_sel;
    logic       window_mode;
  } sowd_wdog_cfg_s;

  typedef struct packed {
    logic       serial2_pin_location;
    logic       twowire_pin_location;
    logic       stop_mode_allow;
    logic       converter_trigger_source;
    logic [2:0] clock_out_divider;
  } sowd_sys_cfg_s;

endpackage : sowd_pkg

// ===== rtl/sowd_top.sv
`timescale 1ns/1ps
// Functional notes
// - First options register: first write only, readable
// - Timeout field 00 disables watchdog
// - 1 kHz source: 2^5, 2^8, 2^10 cycles
// - Bus source: 2^13, 2^16, 2^18 cycles
// - Window mode (bus source only): early status write resets
// - Bus window opens 6144/49152/196608 cycles
// - Stop disallowed means stop is illegal reset
// - Serial2 on F0/F1 or E6/E7
// - Two-wire on F2/F3 or E4/E5
// - Converter trigger: counter overflow or interrupt pin
// - Clock out = bus / (2*divider), zero off
// - Clock select and window bits write once
// - Revision field is hard-wired, read only
// - Part number split across identification registers
// - Service by 0x55 then 0xaa, counter cleared
// - Other status write with watchdog on resets
module sowd_top
  import sowd_pkg::*;
#(
  parameter int         LPO_DIV     = SOWD_LPO_DIV,
  parameter logic [3:0] REVISION    = 4'h1,   // Arbitrary value
  parameter logic [11:0] PART_NUMBER = 12'h5a3  // Arbitrary value
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic [SOWD_AW-1:0] reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  output logic [7:0]              reg_rdata,
  input  wire logic               stop_exec,
  input  wire logic               rtc_overflow,
  input  wire logic               irq_pin_event,
  input  wire logic               converter_hw_trigger_enable,
  output logic                    converter_trigger,
  input  wire logic               serial2_transmit,
  output logic                    serial2_receive,
  input  wire logic               port_f_pin1_in,
  input  wire logic               port_e_pin7_in,
  output logic                    port_f_pin0_out,
  output logic                    port_f_pin0_oe,
  output logic                    port_e_pin6_out,
  output logic                    port_e_pin6_oe,
  input  wire logic               scl_out,
  input  wire logic               scl_oe,
  output logic                    scl_in,
  input  wire logic               sda_out,
  input  wire logic               sda_oe,
  output logic                    sda_in,
  input  wire logic               port_f_pin2_in,
  input  wire logic               port_f_pin3_in,
  input  wire logic               port_e_pin4_in,
  input  wire logic               port_e_pin5_in,
  output logic                    port_f_pin2_out,
  output logic                    port_f_pin2_oe,
  output logic                    port_f_pin3_out,
  output logic                    port_f_pin3_oe,
  output logic                    port_e_pin4_out,
  output logic                    port_e_pin4_oe,
  output logic                    port_e_pin5_out,
  output logic                    port_e_pin5_oe,
  output logic                    port_a_pin0_out,
  output logic                    port_a_pin0_oe,
  output logic                    watchdog_reset,
  output logic                    illegal_opcode_reset
);

  logic        rst_meta;
  logic        rst_sync;
  logic [7:0]  opt1;
  logic [7:0]  opt2;
  logic        opt1_written;
  logic        opt2_written;
  logic [18:0] wd_count;
  logic [18:0] next_wd_count;
  logic        service_armed;
  logic [16:0] lpo_div;
  logic        lpo_tick;
  logic [2:0]  clko_count;
  logic        clko;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Register decode
  wire wr_opt1   = reg_write && reg_addr == SOWD_ADDR_OPT1;
  wire wr_opt2   = reg_write && reg_addr == SOWD_ADDR_OPT2;
  wire wr_status = reg_write && reg_addr == SOWD_ADDR_RST_STATUS;

  sowd_wdog_cfg_s wcfg;
  sowd_sys_cfg_s  scfg;
  assign wcfg.timeout_sel = opt1[SOWD_OPT1_TMO_HI:SOWD_OPT1_TMO_LO];
  assign wcfg.clock_sel   = opt2[SOWD_OPT2_CLKSEL];
  assign wcfg.window_mode = opt2[SOWD_OPT2_WINDOW];
  assign scfg.serial2_pin_location     = opt1[SOWD_OPT1_SER2];
  assign scfg.twowire_pin_location     = opt1[SOWD_OPT1_TWI];
  assign scfg.stop_mode_allow          = opt1[SOWD_OPT1_STOP];
  assign scfg.converter_trigger_source = opt2[SOWD_OPT2_TRIG];
  assign scfg.clock_out_divider        = opt2[SOWD_OPT2_DIV_HI:0];

  // Whole first register locks after one write
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      opt1         <= SOWD_OPT1_RESET;
      opt1_written <= 1'b0;
    end else if (wr_opt1 && !opt1_written) begin
      opt1         <= reg_wdata & SOWD_OPT1_WMASK;
      opt1_written <= 1'b1;
    end
  end

  // Clock select and window lock after one write; trigger and divider bits stay free
  wire [7:0] opt2_lock_mask = (8'h01 << SOWD_OPT2_CLKSEL) | (8'h01 << SOWD_OPT2_WINDOW);
  wire [7:0] opt2_wmask     = opt2_written ? (SOWD_OPT2_WMASK & ~opt2_lock_mask)
                                           : SOWD_OPT2_WMASK;
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      opt2         <= SOWD_OPT2_RESET;
      opt2_written <= 1'b0;
    end else if (wr_opt2) begin
      opt2         <= (opt2 & ~opt2_wmask) | (reg_wdata & opt2_wmask);
      opt2_written <= 1'b1;
    end
  end

  // Read data: one cycle after the read strobe, zero otherwise
  wire [7:0] id_high = {REVISION, PART_NUMBER[11:8]};
  wire [7:0] id_low  = PART_NUMBER[7:0];
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      SOWD_ADDR_OPT1: rd_mux = opt1;
      SOWD_ADDR_OPT2: rd_mux = opt2;
      SOWD_ADDR_IDH:  rd_mux = id_high;
      SOWD_ADDR_IDL:  rd_mux = id_low;
      default:        rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 8'h00;
    end
  end

  // 1 kHz low-power tick
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      lpo_div  <= 17'h00000;
      lpo_tick <= 1'b0;
    end else begin
      lpo_tick <= lpo_div == 17'(LPO_DIV - 1);
      lpo_div  <= (lpo_div == 17'(LPO_DIV - 1)) ? 17'h00000 : lpo_div + 17'h00001;
    end
  end

  function automatic logic [18:0] wd_limit(input logic [1:0] t, input logic bus);
    logic [18:0] r;
    r = 19'h00000;
    unique case (t)
      2'b01:   r = bus ? 19'(1) << SOWD_BUS_EXP1 : 19'(1) << SOWD_LPO_EXP1;
      2'b10:   r = bus ? 19'(1) << SOWD_BUS_EXP2 : 19'(1) << SOWD_LPO_EXP2;
      2'b11:   r = bus ? 19'(1) << SOWD_BUS_EXP3 : 19'(1) << SOWD_LPO_EXP3;
      default: r = 19'h00000;
    endcase
    return r;
  endfunction : wd_limit

  function automatic logic [18:0] wd_window(input logic [1:0] t);
    logic [18:0] r;
    r = 19'h00000;
    unique case (t)
      2'b01:   r = SOWD_WIN_OPEN1;
      2'b10:   r = SOWD_WIN_OPEN2;
      2'b11:   r = SOWD_WIN_OPEN3;
      default: r = 19'h00000;
    endcase
    return r;
  endfunction : wd_window

  wire        wd_enable   = wcfg.timeout_sel != 2'b00;
  wire        wd_step     = wcfg.clock_sel ? 1'b1 : lpo_tick;
  wire [18:0] wd_max      = wd_limit(wcfg.timeout_sel, wcfg.clock_sel);
  // Window only meaningful for the bus source
  wire        window_on   = wcfg.window_mode && wcfg.clock_sel;
  wire        window_shut = window_on && wd_count < wd_window(wcfg.timeout_sel);
  wire        is_first    = reg_wdata == SOWD_SERVICE_FIRST;
  wire        is_second   = reg_wdata == SOWD_SERVICE_SECOND;
  wire        svc_done    = wr_status && service_armed && is_second && !window_shut;
  wire        bad_write   = wr_status && ((!is_first && !is_second) || window_shut);
  wire        overflow    = wd_step && (wd_count + 19'h00001) >= wd_max;

  always_comb begin
    next_wd_count = wd_count;
    // Restart on overflow too, so each timeout gives one pulse
    if (!wd_enable || svc_done || overflow) begin
      next_wd_count = 19'h00000;
    end else if (wd_step) begin
      next_wd_count = wd_count + 19'h00001;
    end
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      wd_count       <= 19'h00000;
      service_armed  <= 1'b0;
      watchdog_reset <= 1'b0;
    end else begin
      wd_count       <= next_wd_count;
      if (wr_status) begin
        service_armed <= is_first && !window_shut;
      end
      watchdog_reset <= wd_enable && ((overflow && !svc_done) || bad_write);
    end
  end

  // Stop instruction policing
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      illegal_opcode_reset <= 1'b0;
    end else begin
      illegal_opcode_reset <= stop_exec && !scfg.stop_mode_allow;
    end
  end

  // Pin routing
  wire s2e = scfg.serial2_pin_location;
  assign port_f_pin0_out = s2e ? 1'b0 : serial2_transmit;
  assign port_f_pin0_oe  = !s2e;
  assign port_e_pin6_out = s2e ? serial2_transmit : 1'b0;
  assign port_e_pin6_oe  = s2e;
  assign serial2_receive = s2e ? port_e_pin7_in : port_f_pin1_in;

  wire twe = scfg.twowire_pin_location;
  assign port_f_pin2_out = scl_out;
  assign port_f_pin2_oe  = !twe && scl_oe;
  assign port_f_pin3_out = sda_out;
  assign port_f_pin3_oe  = !twe && sda_oe;
  assign port_e_pin4_out = scl_out;
  assign port_e_pin4_oe  = twe && scl_oe;
  assign port_e_pin5_out = sda_out;
  assign port_e_pin5_oe  = twe && sda_oe;
  assign scl_in = twe ? port_e_pin4_in : port_f_pin2_in;
  assign sda_in = twe ? port_e_pin5_in : port_f_pin3_in;

  assign converter_trigger = converter_hw_trigger_enable &&
    (scfg.converter_trigger_source ? irq_pin_event : rtc_overflow);

  // Clock out: toggle every divider cycles, period 2*divider
  wire [2:0] div = scfg.clock_out_divider;
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      clko_count <= 3'h0;
      clko       <= 1'b0;
    end else if (div == 3'h0) begin
      clko_count <= 3'h0;
      clko       <= 1'b0;
    end else if (clko_count >= div - 3'h1) begin
      clko_count <= 3'h0;
      clko       <= !clko;
    end else begin
      clko_count <= clko_count + 3'h1;
    end
  end
  assign port_a_pin0_out = clko;
  assign port_a_pin0_oe  = div != 3'h0;

endmodule : sowd_top

// ===== test/sowd_monitor.sv
`timescale 1ns/1ps
module sowd_monitor
  import sowd_pkg::*;
#(
  parameter logic [3:0]  REVISION    = 4'h1,
  parameter logic [11:0] PART_NUMBER = 12'h5a3
) (
  input wire logic               clk,
  input wire logic               rstn,
  input wire logic [SOWD_AW-1:0] reg_addr,
  input wire logic               reg_read,
  input wire logic [7:0]         reg_rdata,
  input wire logic               stop_exec,
  input wire logic               illegal_opcode_reset,
  input wire logic               watchdog_reset,
  input wire logic               serial2_transmit,
  input wire logic               port_f_pin0_out,
  input wire logic               port_f_pin0_oe,
  input wire logic               port_e_pin6_oe,
  input wire logic               rtc_overflow,
  input wire logic               irq_pin_event,
  input wire logic               converter_hw_trigger_enable,
  input wire logic               converter_trigger
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_ident_high_read: assert property (
    reg_read && reg_addr == SOWD_ADDR_IDH |=> reg_rdata == {REVISION, PART_NUMBER[11:8]})
    else $error("high identity read wrong");
  a_ident_low_read: assert property (
    reg_read && reg_addr == SOWD_ADDR_IDL |=> reg_rdata == PART_NUMBER[7:0])
    else $error("low identity read wrong");
  a_stop_cause: assert property (
    illegal_opcode_reset |-> $past(stop_exec))
    else $error("illegal opcode reset without stop");
  a_wdog_single_pulse: assert property (
    watchdog_reset |=> !watchdog_reset [*2])
    else $error("watchdog reset longer than one cycle");
  a_serial_one_owner: assert property (
    port_f_pin0_oe != port_e_pin6_oe)
    else $error("serial transmit driven on both or no pins");
  a_serial_tx_follow: assert property (
    port_f_pin0_oe |-> port_f_pin0_out == serial2_transmit)
    else $error("serial transmit pin does not follow");
  a_trig_gated: assert property (
    !converter_hw_trigger_enable |-> !converter_trigger)
    else $error("converter trigger while disabled");
  a_trig_cause: assert property (
    converter_trigger |-> rtc_overflow || irq_pin_event)
    else $error("converter trigger without source");
  c_wdog: cover property (watchdog_reset);
  c_illegal: cover property (illegal_opcode_reset);
  c_trigger: cover property (converter_trigger);
endmodule : sowd_monitor

bind sowd_top sowd_monitor #(.REVISION(REVISION), .PART_NUMBER(PART_NUMBER)) u_sowd_monitor (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .stop_exec(stop_exec), .illegal_opcode_reset(illegal_opcode_reset),
  .watchdog_reset(watchdog_reset), .serial2_transmit(serial2_transmit),
  .port_f_pin0_out(port_f_pin0_out), .port_f_pin0_oe(port_f_pin0_oe),
  .port_e_pin6_oe(port_e_pin6_oe), .rtc_overflow(rtc_overflow), .irq_pin_event(irq_pin_event),
  .converter_hw_trigger_enable(converter_hw_trigger_enable),
  .converter_trigger(converter_trigger));

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sowd_pkg::*;
  localparam logic [3:0]  REV = 4'h6;    // Arbitrary value
  localparam logic [11:0] PN  = 12'h3c9; // Arbitrary value
  localparam int          DIV = 10;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [2:0]  ad;
  logic [7:0]  wd, rd;
  logic        we, re, trg, srx, scli, sdai, wdr, ilr;
  logic        f0o, f0e, e6o, e6e, f2o, f2e, f3o, f3e, e4o, e4e, e5o, e5e, a0o, a0e;
  logic [14:0] d;
  int          err_count = 0;
  int          tests_run = 0;
  int          n;
  always #5 clk = ~clk;
  sowd_top #(.LPO_DIV(DIV), .REVISION(REV), .PART_NUMBER(PN)) u_sowd_top (
    .clk(clk), .rstn(rstn), .reg_addr(ad), .reg_wdata(wd), .reg_write(we), .reg_read(re),
    .reg_rdata(rd), .stop_exec(d[0]), .rtc_overflow(d[1]), .irq_pin_event(d[2]),
    .converter_hw_trigger_enable(d[3]), .converter_trigger(trg), .serial2_transmit(d[4]),
    .serial2_receive(srx), .port_f_pin1_in(d[5]), .port_e_pin7_in(d[6]), .port_f_pin0_out(f0o),
    .port_f_pin0_oe(f0e), .port_e_pin6_out(e6o), .port_e_pin6_oe(e6e), .scl_out(d[7]),
    .scl_oe(d[8]), .scl_in(scli), .sda_out(d[9]), .sda_oe(d[10]), .sda_in(sdai),
    .port_f_pin2_in(d[11]), .port_f_pin3_in(d[12]), .port_e_pin4_in(d[13]),
    .port_e_pin5_in(d[14]), .port_f_pin2_out(f2o), .port_f_pin2_oe(f2e), .port_f_pin3_out(f3o),
    .port_f_pin3_oe(f3e), .port_e_pin4_out(e4o), .port_e_pin4_oe(e4e), .port_e_pin5_out(e5o),
    .port_e_pin5_oe(e5e), .port_a_pin0_out(a0o), .port_a_pin0_oe(a0e),
    .watchdog_reset(wdr), .illegal_opcode_reset(ilr));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    ad <= a;
    wd <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    ad <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    chk(rd, e);
  endtask : rdc
  // Polls just after each edge so a one-cycle pulse is never missed
  task automatic wt(input bit il, input int mx, output int c);
    for (c = 0; c < mx; c++) begin
      #1;
      if ((il ? ilr : wdr) === 1'b1) break;
      @(posedge clk);
    end
  endtask : wt
  task automatic rst();
    rstn <= 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : rst
  task automatic stop(output int c);
    @(posedge clk);
    d <= 15'h0001;
    @(posedge clk);
    d <= 15'h0000;
    wt(1, 4, c);
  endtask : stop
  task automatic route(input logic [14:0] p, input bit alt);
    @(posedge clk);
    d <= p;
    @(posedge clk);
    #1;
    if (alt) begin
      chk({e6o, e6e, f0e, srx}, {p[4], 2'b10, p[6]});
      chk({e5e, e5o, e4e, e4o, sdai, scli, f3e, f2e}, {p[10:7], p[14:13], 2'b00});
    end else begin
      chk({f0o, f0e, e6e, srx}, {p[4], 2'b10, p[5]});
      chk({f3e, f3o, f2e, f2o, sdai, scli, e5e, e4e}, {p[10:7], p[12:11], 2'b00});
    end
  endtask : route
  task automatic trig(input bit s);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      d <= (i == 0) ? 15'h000a : (i == 1) ? 15'h000c : 15'h0006;
      @(posedge clk);
      #1;
      chk(trg, (i == 0) ? !s : (i == 1) ? s : 1'b0);
    end
  endtask : trig
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  initial begin
    d = '0;
    ad = '0;
    wd = '0;
    we = 1'b0;
    re = 1'b0;
    rst();
    rdc(SOWD_ADDR_OPT1, 8'he0);
    rdc(SOWD_ADDR_OPT2, 8'h00);
    rdc(SOWD_ADDR_IDH, {REV, PN[11:8]});
    rdc(SOWD_ADDR_IDL, PN[7:0]);
    rdc(3'h5, 8'h00);
    route(15'h5a50, 1'b0);
    route(15'h25a0, 1'b0);
    stop(n);
    chk(16'(n), 16'd4);
    $display("test reset_state done");
    wr(SOWD_ADDR_OPT1, 8'h58);
    wr(SOWD_ADDR_OPT1, 8'hff);
    rdc(SOWD_ADDR_OPT1, 8'h58);
    stop(n);
    chk(16'(n < 2), 16'd1);
    route(15'h5a50, 1'b1);
    route(15'h25a0, 1'b1);
    wr(SOWD_ADDR_RST_STATUS, SOWD_SERVICE_FIRST);
    wr(SOWD_ADDR_RST_STATUS, SOWD_SERVICE_SECOND);
    wt(0, 40 * DIV, n);
    chk(16'(n > 29 * DIV && n < 34 * DIV), 16'd1);
    repeat (3) @(posedge clk);
    wr(SOWD_ADDR_RST_STATUS, 8'h12);
    wt(0, 5, n);
    chk(16'(n < 3), 16'd1);
    $display("test write_once_slow_watchdog done");
    rst();
    wr(SOWD_ADDR_OPT1, 8'h00);
    wr(SOWD_ADDR_RST_STATUS, 8'h12);
    #1;
    chk(wdr, 1'b0);
    trig(1'b0);
    wr(SOWD_ADDR_OPT2, 8'hd3);
    wr(SOWD_ADDR_OPT2, 8'h14);
    rdc(SOWD_ADDR_OPT2, 8'hd4);
    trig(1'b1);
    // Half period of the clock output equals the divider
    wt(0, 40, n);
    #1;
    for (n = 0; n < 40 && a0o !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    for (n = 0; n < 40 && a0o !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    for (n = 0; n < 40 && a0o === 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk(a0e, 1'b1);
    chk(16'(n), 16'd4);
    wr(SOWD_ADDR_OPT2, 8'h10);
    rdc(SOWD_ADDR_OPT2, 8'hd0);
    chk(a0e, 1'b0);
    wt(0, 11000, n);
    chk(16'(n), 16'd11000);
    $display("test options_disabled_watchdog done");
    rst();
    wr(SOWD_ADDR_OPT1, 8'h40);
    wr(SOWD_ADDR_OPT2, 8'hc0);
    wr(SOWD_ADDR_RST_STATUS, SOWD_SERVICE_FIRST);
    wt(0, 5, n);
    chk(16'(n < 3), 16'd1);
    rst();
    wr(SOWD_ADDR_OPT1, 8'h40);
    wr(SOWD_ADDR_OPT2, 8'hc0);
    repeat (6200) @(posedge clk);
    wr(SOWD_ADDR_RST_STATUS, SOWD_SERVICE_FIRST);
    wr(SOWD_ADDR_RST_STATUS, SOWD_SERVICE_SECOND);
    wt(0, 8300, n);
    chk(16'(n > 8180 && n < 8200), 16'd1);
    $display("test window_watchdog done");
    wrap_up();
  end
endmodule : tb_top
